/* File: rtl/psram_port_pkg.sv */
package psram_port_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 21;
	localparam int unsigned MEM_AW = 6;
	localparam int unsigned MEM_WORDS = 64;
	localparam int unsigned TIMER_W = 8;
	localparam logic [3:0] LATENCY = 4'h5;
	localparam logic [3:0] BURST_LEN = 4'h4;
	localparam logic [1:0] EDGE_DIV = 2'h2;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned MAX_BURST_NS = 2500;
	localparam int unsigned BURST_END_GAP_NS = 7;
	localparam int unsigned BURST_STOP_GAP_NS = 12;
	localparam int unsigned MAX_BURST_CYC = MAX_BURST_NS * 1000 / CLK_PERIOD_PS;
	localparam int unsigned END_GAP_CYC =
		(BURST_END_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned STOP_GAP_CYC =
		(BURST_STOP_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [DATA_W-1:0] DQ_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] DQ_PULLUP = 16'hffff;

	typedef enum logic [4:0] {
		D_IDLE = 5'b00001,
		D_LAT = 5'b00010,
		D_RD = 5'b00100,
		D_WR = 5'b01000,
		D_HOLD = 5'b10000
	} dev_state_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_GAP = 4'b0010,
		H_CMD = 4'b0100,
		H_BURST = 4'b1000
	} host_state_t;
endpackage

/* File: rtl/psram_link_if.sv */
`timescale 1ns/1ps
interface psram_link_if;
	logic cs_n;
	logic address_valid_strobe_n;
	logic we_n;
	logic oe_n;
	logic upper_byte_enable_n;
	logic lower_byte_enable_n;
	logic [psram_port_pkg::ADDR_W-1:0] addr;
	logic burst_edge;
	logic [psram_port_pkg::DATA_W-1:0] host_dq_o;
	logic host_dq_oe;
	logic [psram_port_pkg::DATA_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic dev_wait_n_o;
	logic dev_wait_oe;
	logic [psram_port_pkg::DATA_W-1:0] dq;
	logic wait_n;

	// wire level with pull-ups when nobody drives
	assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : psram_port_pkg::DQ_PULLUP);
	assign wait_n = dev_wait_oe ? dev_wait_n_o : psram_port_pkg::PIN_IDLE;

	modport dev (
		input cs_n, address_valid_strobe_n, we_n, oe_n,
		input upper_byte_enable_n, lower_byte_enable_n, addr, burst_edge, dq,
		output dev_dq_o, dev_dq_oe, dev_wait_n_o, dev_wait_oe
	);
	modport host (
		output cs_n, address_valid_strobe_n, we_n, oe_n,
		output upper_byte_enable_n, lower_byte_enable_n, addr, burst_edge,
		output host_dq_o, host_dq_oe,
		input dq, wait_n
	);
endinterface

/* File: rtl/psram_dev.sv */
`timescale 1ns/1ps
module psram_dev (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// link
	psram_link_if.dev link,
	// status
	output logic busy,
	output logic write_burst
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	psram_port_pkg::dev_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [psram_port_pkg::ADDR_W-1:0] base_q, base_d;
	logic we_q, we_d;
	logic adv_used_q, adv_used_d;
	logic cs_n_prev_q, cs_n_prev_d;
	logic adv_n_prev_q, adv_n_prev_d;
	logic wait_n_q, wait_n_d;
	logic wait_oe_q, wait_oe_d;
	logic [psram_port_pkg::DATA_W-1:0] dq_o_q, dq_o_d;
	logic dq_oe_q, dq_oe_d;
	logic busy_q, busy_d;
	logic wb_q, wb_d;
	logic [psram_port_pkg::DATA_W-1:0] mem_q [psram_port_pkg::MEM_WORDS];
	logic [psram_port_pkg::DATA_W-1:0] mem_d [psram_port_pkg::MEM_WORDS];

	// write port shared by all entries
	logic wr_en;
	logic [psram_port_pkg::MEM_AW-1:0] wr_idx;
	logic [psram_port_pkg::DATA_W-1:0] wr_data;
	logic [1:0] wr_lane;

	logic cs_fall;
	logic adv_fall;
	logic [3:0] nxt_cnt;
	logic [3:0] word_no;
	logic [psram_port_pkg::MEM_AW-1:0] word_idx;
	logic in_data;
	logic last_word;

	// linear wrap inside the burst length
	function automatic logic [psram_port_pkg::MEM_AW-1:0] wrap_idx(
		input logic [psram_port_pkg::ADDR_W-1:0] base,
		input logic [3:0] word
	);
		logic [1:0] low;
		low = base[1:0] + word[1:0];
		return {base[psram_port_pkg::MEM_AW-1:2], low};
	endfunction

	assign cs_fall = cs_n_prev_q & ~link.cs_n;
	assign adv_fall = adv_n_prev_q & ~link.address_valid_strobe_n;
	assign nxt_cnt = cnt_q + 4'h1;
	assign word_no = nxt_cnt - psram_port_pkg::LATENCY;
	assign word_idx = wrap_idx(base_q, word_no);
	assign in_data = (nxt_cnt >= psram_port_pkg::LATENCY) &&
		(nxt_cnt < psram_port_pkg::LATENCY + psram_port_pkg::BURST_LEN);
	assign last_word = nxt_cnt == psram_port_pkg::LATENCY + psram_port_pkg::BURST_LEN - 4'h1;

	// ------------------------------------------------------------
	// burst control
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		base_d = base_q;
		we_d = we_q;
		adv_used_d = adv_used_q;
		wait_n_d = wait_n_q;
		wait_oe_d = wait_oe_q;
		dq_o_d = dq_o_q;
		cs_n_prev_d = link.cs_n;
		adv_n_prev_d = link.address_valid_strobe_n;
		wr_en = 1'b0;
		wr_idx = word_idx;
		wr_data = link.dq;
		wr_lane = {~link.upper_byte_enable_n, ~link.lower_byte_enable_n};
		if (link.cs_n) begin
			// deselect ends any burst and releases the pins
			state_d = psram_port_pkg::D_IDLE;
			wait_oe_d = 1'b0;
			wait_n_d = psram_port_pkg::PIN_IDLE;
			adv_used_d = 1'b0;
		end else begin
			wait_oe_d = 1'b1;
			if (cs_fall || adv_fall) begin
				wait_n_d = 1'b0;
			end
			if (link.address_valid_strobe_n) begin
				adv_used_d = 1'b0;
			end
			if (link.burst_edge) begin
				if (!link.address_valid_strobe_n && !adv_used_q) begin
					// first edge of the strobe period, also with cs held low
					state_d = psram_port_pkg::D_LAT;
					cnt_d = 4'h1;
					base_d = link.addr;
					we_d = ~link.we_n;
					adv_used_d = 1'b1;
					wait_n_d = 1'b0;
				end else begin
					case (state_q)
						psram_port_pkg::D_LAT,
						psram_port_pkg::D_RD,
						psram_port_pkg::D_WR: begin
							cnt_d = nxt_cnt;
							if (nxt_cnt == psram_port_pkg::LATENCY - 4'h1) begin
								wait_n_d = 1'b1;
							end
							if (in_data && we_q) begin
								// masked word leaves the location alone
								wr_en = |wr_lane;
								state_d = last_word ? psram_port_pkg::D_IDLE
									: psram_port_pkg::D_WR;
							end
							if (in_data && !we_q) begin
								dq_o_d = mem_q[word_idx];
								state_d = last_word ? psram_port_pkg::D_HOLD
									: psram_port_pkg::D_RD;
							end
						end
						psram_port_pkg::D_HOLD: begin
							state_d = psram_port_pkg::D_HOLD;
						end
						psram_port_pkg::D_IDLE: begin
							state_d = psram_port_pkg::D_IDLE;
						end
						default: begin
							state_d = psram_port_pkg::D_IDLE;
						end
					endcase
				end
			end
			// no edge: position and data stay put
		end
	end

	// ------------------------------------------------------------
	// output drive
	// ------------------------------------------------------------
	always_comb begin
		// drive only while selected and output enabled
		dq_oe_d = ~link.cs_n && ~link.oe_n &&
			((state_d == psram_port_pkg::D_RD) || (state_d == psram_port_pkg::D_HOLD));
		busy_d = state_d != psram_port_pkg::D_IDLE;
		wb_d = (state_d != psram_port_pkg::D_IDLE) && we_d;
	end

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	for (genvar i = 0; i < psram_port_pkg::MEM_WORDS; i++) begin : g_word
		always_comb begin
			mem_d[i] = mem_q[i];
			if (wr_en && (wr_idx == psram_port_pkg::MEM_AW'(i))) begin
				if (wr_lane[0]) begin
					mem_d[i][7:0] = wr_data[7:0];
				end
				if (wr_lane[1]) begin
					mem_d[i][15:8] = wr_data[15:8];
				end
			end
		end

		always_ff @(posedge clk_sys or posedge sys_rst) begin
			if (sys_rst) begin
				mem_q[i] <= psram_port_pkg::DQ_RESET;
			end else if (ce) begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= psram_port_pkg::D_IDLE;
			cnt_q <= 4'h0;
			base_q <= '0;
			we_q <= 1'b0;
			adv_used_q <= 1'b0;
			cs_n_prev_q <= psram_port_pkg::PIN_IDLE;
			adv_n_prev_q <= psram_port_pkg::PIN_IDLE;
			wait_n_q <= psram_port_pkg::PIN_IDLE;
			wait_oe_q <= 1'b0;
			dq_o_q <= psram_port_pkg::DQ_RESET;
			dq_oe_q <= 1'b0;
			busy_q <= 1'b0;
			wb_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			base_q <= base_d;
			we_q <= we_d;
			adv_used_q <= adv_used_d;
			cs_n_prev_q <= cs_n_prev_d;
			adv_n_prev_q <= adv_n_prev_d;
			wait_n_q <= wait_n_d;
			wait_oe_q <= wait_oe_d;
			dq_o_q <= dq_o_d;
			dq_oe_q <= dq_oe_d;
			busy_q <= busy_d;
			wb_q <= wb_d;
		end
	end

	assign link.dev_dq_o = dq_o_q;
	assign link.dev_dq_oe = dq_oe_q;
	assign link.dev_wait_n_o = wait_n_q;
	assign link.dev_wait_oe = wait_oe_q;
	assign busy = busy_q;
	assign write_burst = wb_q;
endmodule // psram_dev

/* File: rtl/psram_host.sv */
`timescale 1ns/1ps
module psram_host (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [psram_port_pkg::ADDR_W-1:0] req_addr,
	input wire logic [63:0] req_wdata,
	input wire logic [7:0] req_wmask_n,
	input wire logic stop_req,
	// read data
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [psram_port_pkg::DATA_W-1:0] rd_data,
	// status
	output logic done,
	output logic stopped,
	// link
	psram_link_if.host link
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	psram_port_pkg::host_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] div_q, div_d;
	logic edge_q, edge_d;
	logic wr_q, wr_d;
	logic [63:0] wdat_q, wdat_d;
	logic [7:0] wmask_q, wmask_d;
	logic [psram_port_pkg::TIMER_W-1:0] gap_q, gap_d, bt_q, bt_d, sr_q, sr_d;
	logic cs_n_q, cs_n_d, adv_n_q, adv_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
	logic ube_n_q, ube_n_d, lbe_n_q, lbe_n_d;
	logic [psram_port_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [psram_port_pkg::DATA_W-1:0] dq_o_q, dq_o_d;
	logic dq_oe_q, dq_oe_d;
	logic [psram_port_pkg::DATA_W-1:0] fifo_q [2];
	logic [psram_port_pkg::DATA_W-1:0] fifo_d [2];
	logic [1:0] fcnt_q, fcnt_d;
	logic rdv_q, rdv_d, rdy_q, rdy_d, done_q, done_d, stp_q, stp_d;
	logic [3:0] nc;
	logic [3:0] wsel;
	logic push, pop, stall, run, cut;

	assign nc = cnt_q + 4'h1;
	assign wsel = nc - (psram_port_pkg::LATENCY - 4'h1);
	assign run = (state_q == psram_port_pkg::H_CMD) || (state_q == psram_port_pkg::H_BURST);
	assign stall = !wr_q && (fcnt_q == 2'h2);
	assign pop = rd_ready && rdv_q;
	assign push = edge_q && !wr_q && (state_q == psram_port_pkg::H_BURST) &&
		(nc > psram_port_pkg::LATENCY) &&
		(nc <= psram_port_pkg::LATENCY + psram_port_pkg::BURST_LEN);
	// forced end at the burst ceiling, or a user stop while stops are allowed
	assign cut = (bt_q == psram_port_pkg::TIMER_W'(psram_port_pkg::MAX_BURST_CYC - 1)) ||
		(stop_req && (sr_q < psram_port_pkg::TIMER_W'(psram_port_pkg::MAX_BURST_CYC)));

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		{state_d, cnt_d, wr_d, wdat_d, wmask_d, gap_d} =
			{state_q, cnt_q, wr_q, wdat_q, wmask_q, gap_q};
		{cs_n_d, adv_n_d, we_n_d, oe_n_d, ube_n_d, lbe_n_d} =
			{cs_n_q, adv_n_q, we_n_q, oe_n_q, ube_n_q, lbe_n_q};
		addr_d = addr_q;
		dq_o_d = dq_o_q;
		dq_oe_d = dq_oe_q;
		done_d = 1'b0;
		stp_d = 1'b0;
		bt_d = run ? bt_q + 1'b1 : '0;
		sr_d = (run && sr_q != '1) ? sr_q + 1'b1 : sr_q;
		// read halts the edges while the buffer is full
		div_d = (run && !stall) ? ((div_q == psram_port_pkg::EDGE_DIV - 2'h1) ? 2'h0 : div_q + 2'h1) : div_q;
		edge_d = run && !stall && (div_q == psram_port_pkg::EDGE_DIV - 2'h1);
		case (state_q)
			psram_port_pkg::H_IDLE: begin
				if (req_valid) begin
					// one burst at a time
					state_d = psram_port_pkg::H_CMD;
					{cs_n_d, adv_n_d, we_n_d} = {1'b0, 1'b0, ~req_write};
					addr_d = req_addr;
					wr_d = req_write;
					wdat_d = req_wdata;
					wmask_d = req_wmask_n;
					// for reads, lanes and output enable from the command on; writes keep output enable high and the lanes high until the data words
					oe_n_d = req_write;
					{ube_n_d, lbe_n_d} = req_write ? 2'b11 : 2'b00;
				end
			end
			psram_port_pkg::H_CMD: begin
				if (edge_q) begin
					state_d = psram_port_pkg::H_BURST;
					cnt_d = 4'h1;
					adv_n_d = psram_port_pkg::PIN_IDLE;
				end
			end
			psram_port_pkg::H_BURST: begin
				if (cut) begin
					// early stop by deselect
					state_d = psram_port_pkg::H_GAP;
					{cs_n_d, oe_n_d, ube_n_d, lbe_n_d} = 4'hf;
					dq_oe_d = 1'b0;
					gap_d = psram_port_pkg::TIMER_W'(psram_port_pkg::STOP_GAP_CYC);
					stp_d = 1'b1;
				end else if (edge_q) begin
					cnt_d = nc;
					if (wr_q && wsel < psram_port_pkg::BURST_LEN) begin
						dq_o_d = wdat_q[wsel[1:0]*16 +: 16];
						{ube_n_d, lbe_n_d} = wmask_q[wsel[1:0]*2 +: 2];
						dq_oe_d = 1'b1;
					end
					if (nc == psram_port_pkg::LATENCY + psram_port_pkg::BURST_LEN -
						(wr_q ? 4'h1 : 4'h0)) begin
						state_d = psram_port_pkg::H_GAP;
						{cs_n_d, oe_n_d, ube_n_d, lbe_n_d} = 4'hf;
						dq_oe_d = 1'b0;
						gap_d = psram_port_pkg::TIMER_W'(psram_port_pkg::END_GAP_CYC);
						done_d = 1'b1;
						sr_d = '0;
					end
				end
			end
			psram_port_pkg::H_GAP: begin
				gap_d = gap_q - 1'b1;
				if (gap_q <= psram_port_pkg::TIMER_W'(1)) begin
					state_d = psram_port_pkg::H_IDLE;
				end
			end
			default: begin
				state_d = psram_port_pkg::H_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// read buffer
	// ------------------------------------------------------------
	always_comb begin
		fifo_d = fifo_q;
		fcnt_d = fcnt_q;
		if (pop) begin
			fifo_d[0] = fifo_q[1];
			fcnt_d = fcnt_d - 2'h1;
		end
		if (push) begin
			fifo_d[fcnt_d[0]] = link.dq;
			fcnt_d = fcnt_d + 2'h1;
		end
		rdv_d = fcnt_d != 2'h0;
		rdy_d = state_d == psram_port_pkg::H_IDLE;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= psram_port_pkg::H_IDLE;
			{cnt_q, div_q, edge_q, wr_q, wdat_q, wmask_q} <= '0;
			{gap_q, bt_q, sr_q} <= '0;
			{cs_n_q, adv_n_q, we_n_q, oe_n_q, ube_n_q, lbe_n_q} <= 6'h3f;
			addr_q <= '0;
			dq_o_q <= psram_port_pkg::DQ_RESET;
			dq_oe_q <= 1'b0;
			fifo_q[0] <= psram_port_pkg::DQ_RESET;
			fifo_q[1] <= psram_port_pkg::DQ_RESET;
			{fcnt_q, rdv_q, rdy_q, done_q, stp_q} <= '0;
		end else if (ce) begin
			state_q <= state_d;
			{cnt_q, div_q, edge_q, wr_q, wdat_q, wmask_q} <=
				{cnt_d, div_d, edge_d, wr_d, wdat_d, wmask_d};
			{gap_q, bt_q, sr_q} <= {gap_d, bt_d, sr_d};
			{cs_n_q, adv_n_q, we_n_q, oe_n_q, ube_n_q, lbe_n_q} <=
				{cs_n_d, adv_n_d, we_n_d, oe_n_d, ube_n_d, lbe_n_d};
			addr_q <= addr_d;
			dq_o_q <= dq_o_d;
			dq_oe_q <= dq_oe_d;
			fifo_q <= fifo_d;
			{fcnt_q, rdv_q, rdy_q, done_q, stp_q} <= {fcnt_d, rdv_d, rdy_d, done_d, stp_d};
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.address_valid_strobe_n = adv_n_q;
	assign link.we_n = we_n_q;
	assign link.oe_n = oe_n_q;
	assign link.upper_byte_enable_n = ube_n_q;
	assign link.lower_byte_enable_n = lbe_n_q;
	assign link.addr = addr_q;
	assign link.burst_edge = edge_q;
	assign link.host_dq_o = dq_o_q;
	assign link.host_dq_oe = dq_oe_q;
	assign req_ready = rdy_q;
	assign rd_valid = rdv_q;
	assign rd_data = fifo_q[0];
	assign done = done_q;
	assign stopped = stp_q;
endmodule // psram_host

/* File: sim/psram_link_chk.sv */
`timescale 1ns/1ps
module psram_link_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// host side
	input wire logic cs_n,
	input wire logic address_valid_strobe_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic upper_byte_enable_n,
	input wire logic lower_byte_enable_n,
	input wire logic burst_edge,
	// device side
	input wire logic [psram_port_pkg::DATA_W-1:0] dev_dq_o,
	input wire logic dev_dq_oe,
	input wire logic dev_wait_n_o,
	input wire logic dev_wait_oe
);
	localparam logic [3:0] LAT = psram_port_pkg::LATENCY;
	logic used_q, used_d, start;
	logic [3:0] cnt_q, cnt_d;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// burst edge count
	// ----------------------------------------
	always_comb begin
		start = burst_edge && !cs_n && !address_valid_strobe_n && !used_q;
		used_d = !address_valid_strobe_n && (used_q || start);
		cnt_d = cnt_q;
		if (cs_n) begin
			cnt_d = 4'h0;
		end else if (start) begin
			cnt_d = 4'h1;
		end else if (burst_edge && cnt_q != 4'h0 && cnt_q != 4'hf) begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			used_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			used_q <= used_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	wait_low_a: assert property (
		($fell(cs_n) || $fell(address_valid_strobe_n)) && !cs_n |=> dev_wait_oe && !dev_wait_n_o)
		else $error("wait not low after select");
	wait_hold_a: assert property (
		!cs_n && cnt_q >= 4'h1 && cnt_q <= LAT - 4'h2 |-> !dev_wait_n_o)
		else $error("wait released early");
	wait_high_a: assert property (
		burst_edge && !cs_n && cnt_q == LAT - 4'h2 |=> dev_wait_oe && dev_wait_n_o)
		else $error("wait not released after latency minus one");
	data_start_a: assert property (
		burst_edge && !cs_n && !oe_n && we_n && cnt_q == LAT - 4'h1 |=> dev_dq_oe)
		else $error("read data not driven at latency");
	data_hold_a: assert property (
		dev_dq_oe && $past(dev_dq_oe) && !$past(burst_edge) |-> $stable(dev_dq_o))
		else $error("read word changed without clock edge");
	oe_float_a: assert property (
		oe_n && $past(oe_n) |-> !dev_dq_oe)
		else $error("data driven with output disabled");
	data_float_a: assert property (
		$rose(cs_n) |=> !dev_dq_oe && !dev_wait_oe)
		else $error("pins driven after deselect");
	lane_lead_a: assert property (
		burst_edge && !cs_n && we_n && cnt_q == LAT - 4'h2
		|-> !oe_n && !upper_byte_enable_n && !lower_byte_enable_n)
		else $error("lanes or output enable late");
	strobe_gap_a: assert property (
		$rose(cs_n) |-> address_valid_strobe_n[*2])
		else $error("strobe too soon after burst end");

	read_cov: cover property (burst_edge && !cs_n && we_n && cnt_q == LAT - 4'h1);
	write_cov: cover property (burst_edge && !cs_n && !we_n && cnt_q == LAT - 4'h1);
	suspend_cov: cover property (dev_dq_oe && !burst_edge [*4]);
	stop_cov: cover property ($rose(cs_n) && cnt_q < LAT);
endmodule // psram_link_chk

/* File: sim/sync_burst_psram_port_tb.sv */
`timescale 1ns/1ps
module sync_burst_psram_port_tb;
	logic clk_sys, sys_rst, ce, req_valid, req_write, stop_req, rd_ready;
	logic [psram_port_pkg::ADDR_W-1:0] req_addr;
	logic [63:0] req_wdata;
	logic [7:0] req_wmask_n;
	logic req_ready, rd_valid, done, stopped, busy, write_burst;
	logic [psram_port_pkg::DATA_W-1:0] rd_data;
	logic [15:0] mem [0:63];
	int n_errors, comparisons, cyc;

	psram_link_if link_if ();
	psram_dev psram_dev_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.link(link_if.dev), .busy(busy), .write_burst(write_burst));
	psram_host psram_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_wmask_n(req_wmask_n),
		.stop_req(stop_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.done(done), .stopped(stopped), .link(link_if.host));
	psram_link_chk psram_link_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.cs_n(link_if.cs_n), .address_valid_strobe_n(link_if.address_valid_strobe_n),
		.we_n(link_if.we_n), .oe_n(link_if.oe_n),
		.upper_byte_enable_n(link_if.upper_byte_enable_n),
		.lower_byte_enable_n(link_if.lower_byte_enable_n), .burst_edge(link_if.burst_edge),
		.dev_dq_o(link_if.dev_dq_o), .dev_dq_oe(link_if.dev_dq_oe),
		.dev_wait_n_o(link_if.dev_wait_n_o), .dev_wait_oe(link_if.dev_wait_oe));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(negedge clk_sys);
		cyc++;
		if (cyc > 500) begin
			n_errors++;
			finish_test();
		end
	endtask

	// wrap inside the aligned group of four
	function automatic logic [5:0] idx(input logic [5:0] a, input logic [1:0] k);
		return {a[5:2], a[1:0] + k};
	endfunction

	// one burst: request, collect words, check the ending
	task automatic run(input logic wr, input logic [20:0] addr, input logic [63:0] wdata,
		input logic [7:0] mask, input logic stop, input int stall, input logic exp_stop);
		int n = 0;
		logic got_done = 1'b0;
		logic got_stop = 1'b0;
		logic saw_wb = 1'b0;
		logic saw_busy = 1'b0;
		logic [15:0] w;
		cyc = 0;
		while (req_ready !== 1'b1) tick();
		check(16'(busy), 16'h0);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = addr;
		req_wdata = wdata;
		req_wmask_n = mask;
		stop_req = stop;
		tick();
		req_valid = 1'b0;
		cyc = 0;
		while (!((n == 4 && got_done) || (wr && got_done) || (got_stop && cyc > stall + 10))) begin
			rd_ready = (cyc >= stall);
			if (rd_valid === 1'b1 && rd_ready) begin
				check(rd_data, mem[idx(addr[5:0], n[1:0])]);
				n++;
			end
			got_done |= (done === 1'b1);
			got_stop |= (stopped === 1'b1);
			saw_wb |= (write_burst === 1'b1);
			saw_busy |= (busy === 1'b1);
			tick();
		end
		check(16'(saw_busy), 16'h1);
		check(16'(got_stop), 16'(exp_stop));
		check(16'(got_done), 16'(!exp_stop));
		check(16'(saw_wb), 16'(wr));
		if (exp_stop && stall == 0) check(16'(n), 16'h0);
		stop_req = 1'b0;
		rd_ready = 1'b1;
		if (wr && !got_stop) begin
			for (int k = 0; k < 4; k++) begin
				w = mem[idx(addr[5:0], k[1:0])];
				if (!mask[2*k]) w[7:0] = wdata[16*k +: 8];
				if (!mask[2*k+1]) w[15:8] = wdata[16*k+8 +: 8];
				mem[idx(addr[5:0], k[1:0])] = w;
			end
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		req_wmask_n = 8'h00;
		stop_req = 1'b0;
		rd_ready = 1'b1;
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		run(1'b1, 21'h000000, 64'h4444_3333_2222_1111, 8'h00, 1'b0, 0, 1'b0);
		run(1'b1, 21'h000004, 64'h8888_7777_6666_5555, 8'h00, 1'b0, 0, 1'b0);
		run(1'b0, 21'h000000, '0, 8'h00, 1'b0, 0, 1'b0);
		run(1'b0, 21'h100006, '0, 8'h00, 1'b0, 0, 1'b0);
		run(1'b1, 21'h000005, 64'hdddd_cccc_bbbb_aaaa, 8'h38, 1'b0, 0, 1'b0);
		run(1'b0, 21'h000004, '0, 8'h00, 1'b0, 0, 1'b0);
		ce = 1'b0;
		repeat (3) @(negedge clk_sys);
		ce = 1'b1;
		run(1'b0, 21'h000001, '0, 8'h00, 1'b0, 40, 1'b0);
		run(1'b0, 21'h000002, '0, 8'h00, 1'b0, 150, 1'b1);
		run(1'b0, 21'h000003, '0, 8'h00, 1'b0, 0, 1'b0);
		run(1'b0, 21'h000000, '0, 8'h00, 1'b1, 0, 1'b1);
		run(1'b1, 21'h000000, 64'hffff_eeee_dddd_cccc, 8'h00, 1'b1, 0, 1'b1);
		run(1'b0, 21'h000000, '0, 8'h00, 1'b0, 0, 1'b0);
		finish_test();
	end
endmodule // sync_burst_psram_port_tb
